// file: verilog/irq_prio_pkg.sv
// Package for the two-level interrupt priority unit: register map,
// field positions, reset values, poll order, vectors and carrier types.
// Assumes the core's special-function register bus and bit-write port.
package irq_prio_pkg;

  // Register addresses on the special-function bus
  localparam logic [7:0] IRQ_ENABLE_ADDR   = 8'ha8;
  localparam logic [7:0] SEC_EN_PRIO_ADDR  = 8'ha9;
  localparam logic [7:0] IRQ_PRIO_ADDR     = 8'hb8;

  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RST    = 8'h00;
  localparam logic [7:0] SEC_EN_PRIO_RST   = 8'ha0;
  localparam logic [7:0] IRQ_PRIO_RST      = 8'h00;

  // Field positions in the primary enable and priority registers
  localparam int GLOBAL_EN_BIT = 7;
  localparam int ADC_BIT       = 6;
  localparam int T2_BIT        = 5;
  localparam int UART_BIT      = 4;
  localparam int T1_BIT        = 3;
  localparam int EXT1_BIT      = 2;
  localparam int T0_BIT        = 1;
  localparam int EXT0_BIT      = 0;

  // Field positions in the secondary register
  localparam int SEC_RSVD_HI_BIT  = 7;
  localparam int TIC_PRIO_BIT     = 6;
  localparam int PSM_PRIO_BIT     = 5;
  localparam int SPI_PRIO_BIT     = 4;
  localparam int SEC_RSVD_LO_BIT  = 3;
  localparam int TIC_EN_BIT       = 2;
  localparam int PSM_EN_BIT       = 1;
  localparam int SPI_EN_BIT       = 0;

  // Slots in poll order, highest first
  localparam int NSLOT     = 11;
  localparam int SLOT_PSM  = 0;
  localparam int SLOT_WDT  = 1;
  localparam int SLOT_EXT0 = 2;
  localparam int SLOT_ADC  = 3;
  localparam int SLOT_T0   = 4;
  localparam int SLOT_EXT1 = 5;
  localparam int SLOT_T1   = 6;
  localparam int SLOT_SPI  = 7;
  localparam int SLOT_UART = 8;
  localparam int SLOT_T2   = 9;
  localparam int SLOT_TIC  = 10;

  // Vector address per slot
  localparam logic [NSLOT-1:0][15:0] VECTORS = {
    16'h0053, 16'h002b, 16'h0023, 16'h003b, 16'h001b, 16'h0013,
    16'h000b, 16'h0033, 16'h0003, 16'h005b, 16'h0043};

  // Raw request lines from the peripherals, thirteen flags
  typedef struct packed {
    logic supply_monitor_flag;
    logic ext0_flag;
    logic adc_done_flag0;
    logic adc_done_flag1;
    logic timer0_overflow_flag;
    logic ext1_flag;
    logic timer1_overflow_flag;
    logic spi_flag;
    logic rx_done_flag;
    logic tx_done_flag;
    logic timer2_overflow_flag;
    logic timer2_ext_flag;
    logic interval_counter_flag;
  } irq_flags_s;

  // Request to the core
  typedef struct packed {
    logic        req;
    logic        high;
    logic [3:0]  slot;
    logic [15:0] vector;
  } irq_req_s;

endpackage : irq_prio_pkg

// file: verilog/irq_prio_unit.sv
// Two-level interrupt priority unit with watchdog interrupt path.
// Assumes peripheral flags and the core strobes are on core_clk.
//
// Contract
// - Eleven sources, two priority levels
// - Enable bit 7 blocks all maskable sources
// - Enable bits 6..0 gate seven sources
// - Priority bits 6..0 set level, bit7 reserved
// - Secondary bits 6..4 priority, 2..0 enable
// - High request preempts low service routine
// - Same cycle: high level vectored first
// - Same level held off until routine ends
// - Fixed poll order within a level
// - Acceptance pushes PC, loads vector
// - Fixed vector address per source
// - Watchdog select turns reset into interrupt
// - Watchdog always high, ignores global enable
// - Watchdog requests only with nonzero period
// - Secondary resets A0H, not bit addressable
// - SPI wake needs wake enable bit
`timescale 1ns/100ps
`default_nettype none
module irq_prio_unit (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  input  wire logic [7:0]               bit_addr,
  input  wire logic                     bit_wr,
  input  wire logic                     bit_wdata,
  input  wire irq_prio_pkg::irq_flags_s flags,
  input  wire logic                     wdt_timeout,
  input  wire logic                     watchdog_irq_select,
  input  wire logic                     wdt_period_nonzero,
  input  wire logic                     wdt_flag_clr,
  input  wire logic                     spi_wake_enable,
  input  wire logic                     power_down,
  output logic                          wake_req,
  output logic                          wdt_reset_req,
  output logic                          watchdog_flag,
  output irq_prio_pkg::irq_req_s        irq_out,
  input  wire logic                     irq_ack,
  input  wire logic                     reti
);

  typedef struct packed {
    logic [7:0]            ie;
    logic [7:0]            ip;
    logic [7:0]            sec;
    logic                  wdt_flag;
    logic                  wdt_rst;
    logic                  act_hi;
    logic                  act_lo;
    logic [7:0]            rdata;
    irq_prio_pkg::irq_req_s out;
  } state_s;

  state_s q;
  state_s d;

  logic [irq_prio_pkg::NSLOT-1:0] raw;
  logic [irq_prio_pkg::NSLOT-1:0] enab;
  logic [irq_prio_pkg::NSLOT-1:0] prio;
  logic [irq_prio_pkg::NSLOT-1:0] pend_hi;
  logic [irq_prio_pkg::NSLOT-1:0] pend_lo;
  logic                           take;

  // Lowest set index wins, which is the poll order
  function automatic logic [3:0] first_set(
    input logic [irq_prio_pkg::NSLOT-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = irq_prio_pkg::NSLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  // Merge flag pairs into one request per vector slot
  always_comb begin
    raw                          = '0;
    raw[irq_prio_pkg::SLOT_PSM]  = flags.supply_monitor_flag;
    raw[irq_prio_pkg::SLOT_WDT]  = q.wdt_flag;
    raw[irq_prio_pkg::SLOT_EXT0] = flags.ext0_flag;
    raw[irq_prio_pkg::SLOT_ADC]  = flags.adc_done_flag0 |
                                   flags.adc_done_flag1;
    raw[irq_prio_pkg::SLOT_T0]   = flags.timer0_overflow_flag;
    raw[irq_prio_pkg::SLOT_EXT1] = flags.ext1_flag;
    raw[irq_prio_pkg::SLOT_T1]   = flags.timer1_overflow_flag;
    raw[irq_prio_pkg::SLOT_SPI]  = flags.spi_flag;
    raw[irq_prio_pkg::SLOT_UART] = flags.rx_done_flag | flags.tx_done_flag;
    raw[irq_prio_pkg::SLOT_T2]   = flags.timer2_overflow_flag |
                                   flags.timer2_ext_flag;
    raw[irq_prio_pkg::SLOT_TIC]  = flags.interval_counter_flag;
  end

  // Per-slot enable and level from the three registers
  always_comb begin
    enab = '0;
    prio = '0;
    enab[irq_prio_pkg::SLOT_EXT0] = q.ie[irq_prio_pkg::EXT0_BIT];
    enab[irq_prio_pkg::SLOT_T0]   = q.ie[irq_prio_pkg::T0_BIT];
    enab[irq_prio_pkg::SLOT_EXT1] = q.ie[irq_prio_pkg::EXT1_BIT];
    enab[irq_prio_pkg::SLOT_T1]   = q.ie[irq_prio_pkg::T1_BIT];
    enab[irq_prio_pkg::SLOT_UART] = q.ie[irq_prio_pkg::UART_BIT];
    enab[irq_prio_pkg::SLOT_T2]   = q.ie[irq_prio_pkg::T2_BIT];
    enab[irq_prio_pkg::SLOT_ADC]  = q.ie[irq_prio_pkg::ADC_BIT];
    enab[irq_prio_pkg::SLOT_TIC]  = q.sec[irq_prio_pkg::TIC_EN_BIT];
    enab[irq_prio_pkg::SLOT_PSM]  = q.sec[irq_prio_pkg::PSM_EN_BIT];
    enab[irq_prio_pkg::SLOT_SPI]  = q.sec[irq_prio_pkg::SPI_EN_BIT];
    prio[irq_prio_pkg::SLOT_EXT0] = q.ip[irq_prio_pkg::EXT0_BIT];
    prio[irq_prio_pkg::SLOT_T0]   = q.ip[irq_prio_pkg::T0_BIT];
    prio[irq_prio_pkg::SLOT_EXT1] = q.ip[irq_prio_pkg::EXT1_BIT];
    prio[irq_prio_pkg::SLOT_T1]   = q.ip[irq_prio_pkg::T1_BIT];
    prio[irq_prio_pkg::SLOT_UART] = q.ip[irq_prio_pkg::UART_BIT];
    prio[irq_prio_pkg::SLOT_T2]   = q.ip[irq_prio_pkg::T2_BIT];
    prio[irq_prio_pkg::SLOT_ADC]  = q.ip[irq_prio_pkg::ADC_BIT];
    prio[irq_prio_pkg::SLOT_TIC]  = q.sec[irq_prio_pkg::TIC_PRIO_BIT];
    prio[irq_prio_pkg::SLOT_PSM]  = q.sec[irq_prio_pkg::PSM_PRIO_BIT];
    prio[irq_prio_pkg::SLOT_SPI]  = q.sec[irq_prio_pkg::SPI_PRIO_BIT];
    // Watchdog is always high and skips the global gate
    enab[irq_prio_pkg::SLOT_WDT]  = 1'b1;
    prio[irq_prio_pkg::SLOT_WDT]  = 1'b1;
  end

  // Split pending requests by level, global gate on maskable ones
  for (genvar g = 0; g < irq_prio_pkg::NSLOT; g++) begin : g_pend
    logic live;
    if (g == irq_prio_pkg::SLOT_WDT) begin : g_wdt
      assign live = raw[g];
    end else begin : g_mask
      assign live = raw[g] & enab[g] &
                    q.ie[irq_prio_pkg::GLOBAL_EN_BIT];
    end
    assign pend_hi[g] = live & prio[g];
    assign pend_lo[g] = live & ~prio[g];
  end

  assign take = irq_ack & q.out.req;

  // Next state: registers, watchdog flag, service levels, request
  always_comb begin
    d = q;
    // Byte writes over the register bus
    if (sfr_wr) begin
      unique case (sfr_addr)
        irq_prio_pkg::IRQ_ENABLE_ADDR: d.ie = sfr_wdata;
        irq_prio_pkg::IRQ_PRIO_ADDR: begin
          d.ip = {1'b0, sfr_wdata[6:0]};
        end
        irq_prio_pkg::SEC_EN_PRIO_ADDR: begin
          d.sec = sfr_wdata;
          d.sec[irq_prio_pkg::SEC_RSVD_HI_BIT] =
            irq_prio_pkg::SEC_EN_PRIO_RST[irq_prio_pkg::SEC_RSVD_HI_BIT];
        end
        default: ;
      endcase
    end
    // Bit writes reach only the primary registers
    if (bit_wr) begin
      if (bit_addr[7:3] == irq_prio_pkg::IRQ_ENABLE_ADDR[7:3]) begin
        d.ie[bit_addr[2:0]] = bit_wdata;
      end else if (bit_addr[7:3] == irq_prio_pkg::IRQ_PRIO_ADDR[7:3]
                   && bit_addr[2:0] != 3'h7) begin
        d.ip[bit_addr[2:0]] = bit_wdata;
      end
    end
    // Watchdog timeout: interrupt when selected with nonzero period, reset request when not selected
    d.wdt_rst = wdt_timeout & ~watchdog_irq_select;
    if (take && q.out.slot == 4'(irq_prio_pkg::SLOT_WDT)) begin
      d.wdt_flag = 1'b0;
    end
    if (wdt_flag_clr) begin
      d.wdt_flag = 1'b0;
    end
    if (wdt_timeout && watchdog_irq_select && wdt_period_nonzero) begin
      d.wdt_flag = 1'b1;
    end
    // Return drops the innermost level, acceptance marks its level
    if (reti) begin
      if (q.act_hi) begin
        d.act_hi = 1'b0;
      end else begin
        d.act_lo = 1'b0;
      end
    end
    if (take) begin
      if (q.out.high) begin
        d.act_hi = 1'b1;
      end else begin
        d.act_lo = 1'b1;
      end
    end
    // Arbitrate against the updated levels
    d.out.req = 1'b0;
    d.out.high = 1'b0;
    d.out.slot = q.out.slot;
    if (!d.act_hi && |pend_hi) begin
      d.out.req = 1'b1;
      d.out.high = 1'b1;
      d.out.slot = first_set(pend_hi);
    end else if (!d.act_hi && !d.act_lo && |pend_lo) begin
      d.out.req = 1'b1;
      d.out.slot = first_set(pend_lo);
    end
    d.out.vector = irq_prio_pkg::VECTORS[d.out.slot];
    // Registered read-back, unmapped addresses read zero
    unique case (sfr_addr)
      irq_prio_pkg::IRQ_ENABLE_ADDR:  d.rdata = d.ie;
      irq_prio_pkg::IRQ_PRIO_ADDR:    d.rdata = d.ip;
      irq_prio_pkg::SEC_EN_PRIO_ADDR: d.rdata = d.sec;
      default:                        d.rdata = 8'h00;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q          <= '0;
      q.ie       <= irq_prio_pkg::IRQ_ENABLE_RST;
      q.ip       <= irq_prio_pkg::IRQ_PRIO_RST;
      q.sec      <= irq_prio_pkg::SEC_EN_PRIO_RST;
      q.out.vector <= irq_prio_pkg::VECTORS[0];
    end else begin
      q <= d;
    end
  end

  // Outputs; the core pushes PC and jumps on acknowledge
  assign irq_out       = q.out;
  assign sfr_rdata     = q.rdata;
  assign wdt_reset_req = q.wdt_rst;
  assign watchdog_flag = q.wdt_flag;
  assign wake_req      = power_down &
    ((raw[irq_prio_pkg::SLOT_SPI] & enab[irq_prio_pkg::SLOT_SPI] &
      spi_wake_enable) |
     (raw[irq_prio_pkg::SLOT_TIC] & enab[irq_prio_pkg::SLOT_TIC]));

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  gate_blocks_lo_a: assert property (
    (!q.ie[7] && !q.wdt_flag) |=> !q.out.req)
    else $error("Request raised with global enable clear");
  wdt_unmasked_a: assert property (
    (q.wdt_flag && !q.act_hi && !irq_ack && !wdt_flag_clr && !reti)
      |=> q.out.req && q.out.high)
    else $error("Watchdog request not raised at high level");
  wdt_vector_a: assert property (
    (q.out.req && q.out.slot == 4'h1) |-> q.out.vector == 16'h005b)
    else $error("Watchdog vector wrong");
  ext0_vector_a: assert property (
    (q.out.req && q.out.slot == 4'h2) |-> q.out.vector == 16'h0003)
    else $error("External 0 vector wrong");
  same_level_a: assert property (
    q.act_hi |-> !q.out.req)
    else $error("Request raised during high-level service");
  lo_held_a: assert property (
    (q.act_lo && q.out.req) |-> q.out.high)
    else $error("Low request raised during low service");
  preempt_a: assert property (
    (q.act_lo && !q.act_hi && $stable(q.act_lo) && |pend_hi
     && !irq_ack && !reti) |=> q.out.req && q.out.high)
    else $error("High request failed to preempt");
  wdt_period_a: assert property (
    (wdt_timeout && !wdt_period_nonzero && !q.wdt_flag) |=> !q.wdt_flag)
    else $error("Watchdog flag set with zero period");
  wdt_reset_a: assert property (
    (wdt_timeout && !watchdog_irq_select) |=> wdt_reset_req ##1
      !wdt_reset_req || $past(wdt_timeout))
    else $error("Watchdog reset request missing");
  reti_clear_a: assert property (
    (reti && !irq_ack && q.act_hi) |=> !q.act_hi)
    else $error("Return left high level active");
  sec_rsvd_a: assert property (
    q.sec[7] == 1'b1)
    else $error("Secondary reserved bit changed");
  ip_rsvd_a: assert property (
    q.ip[7] == 1'b0)
    else $error("Priority reserved bit changed");
  psm_vector_a: assert property (
    (q.out.req && q.out.slot == 4'h0) |-> q.out.vector == 16'h0043)
    else $error("Supply monitor vector wrong");
  wdt_ack_clr_a: assert property (
    (take && q.out.slot == 4'h1 && !wdt_timeout) |=> !q.wdt_flag)
    else $error("Watchdog flag kept after acknowledge");
  hi_first_a: assert property (
    (!q.act_hi && !q.act_lo && |pend_hi && |pend_lo && !irq_ack && !reti)
      |=> q.out.req && q.out.high)
    else $error("Low request chosen over high");

  hi_over_lo_c: cover property (q.act_lo ##1 q.act_lo && q.act_hi);
  wdt_irq_c: cover property (q.wdt_flag ##[1:4] take);
  nested_ret_c: cover property (q.act_hi && q.act_lo ##1 reti);
  lo_taken_c: cover property (take && !q.out.high);

endmodule : irq_prio_unit
`default_nettype wire

// file: bench/core_model.sv
// Processor core model: takes interrupt requests and returns from service.
// Assumes the unit's request stands until acknowledged or withdrawn.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire irq_prio_pkg::irq_req_s irq_out,
  input  wire logic                   ack_en,
  input  wire logic [3:0]             ack_wait,
  input  wire logic                   ret_cmd,
  output logic                        irq_ack,
  output logic                        reti,
  output logic [15:0]                 pc,
  output logic [7:0]                  depth
);
  logic [15:0] stk[$];
  int          cnt  = 0;
  int          cool = 0;
  logic        en_s;
  logic        ret_s;

  // One process drives all outputs: quiet from time zero, then sample at
  // each edge and answer just after it; ack may wait ack_wait cycles
  initial begin
    irq_ack = 1'b0;
    reti    = 1'b0;
    pc      = 16'h0100;
    depth   = 8'h00;
    forever begin
      @(posedge core_clk);
      en_s  = ack_en;
      ret_s = ret_cmd;
      if (irq_ack && irq_out.req) begin
        stk.push_back(pc);
        pc   = irq_out.vector;
        cool = 2;
      end
      if (reti && stk.size() > 0) pc = stk.pop_back();
      if (rst) stk.delete();
      depth = 8'(stk.size());
      #1;
      reti    = ret_s && !rst;
      irq_ack = !rst && !ret_s && cool == 0 && en_s && irq_out.req &&
                cnt >= int'(ack_wait);
      cnt     = (en_s && irq_out.req && !irq_ack) ? cnt + 1 : 0;
      if (cool > 0) cool--;
    end
  end
endmodule : core_model
`default_nettype wire

// file: bench/tb.sv
// Testbench for the interrupt priority unit with a reference model.
// Assumes core_model.sv and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, bit_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic       bit_wdata = 1'b0, tmo = 1'b0, wd_sel = 1'b0, wd_nz = 1'b0;
  logic       wd_clr = 1'b0, spi_wk = 1'b0, pdown = 1'b0, ack_en = 1'b0;
  logic       ret_cmd = 1'b0, wake_req, wdt_reset_req, watchdog_flag;
  logic       irq_ack, reti, act_hi = 1'b0, act_lo = 1'b0, wdt = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [7:0] sfr_rdata, depth, en_r = 8'h00, pr_r = 8'h00, sec_r = 8'ha0;
  logic [15:0] pc;
  logic [31:0] seed = 32'h3d91, r;
  int          checks = 0, bad_count = 0, cycles = 0;
  irq_prio_pkg::irq_req_s   irq_out;
  irq_prio_pkg::irq_flags_s fl = '0;
  logic [15:0] vec [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033,
    16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

  irq_prio_unit dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
    .flags(fl), .wdt_timeout(tmo), .watchdog_irq_select(wd_sel),
    .wdt_period_nonzero(wd_nz), .wdt_flag_clr(wd_clr),
    .spi_wake_enable(spi_wk), .power_down(pdown), .wake_req(wake_req),
    .wdt_reset_req(wdt_reset_req), .watchdog_flag(watchdog_flag),
    .irq_out(irq_out), .irq_ack(irq_ack), .reti(reti));
  core_model core (.core_clk(core_clk), .rst(rst), .irq_out(irq_out),
    .ack_en(ack_en), .ack_wait(ack_wait), .ret_cmd(ret_cmd),
    .irq_ack(irq_ack), .reti(reti), .pc(pc), .depth(depth));

  // 200 MHz clock and a cycle ceiling against hangs
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // Reference pick: returns slot + 16 * level, or -1 when nothing is due
  function automatic int pick();
    logic [10:0] p, e, h;
    p = {fl.interval_counter_flag, fl.timer2_overflow_flag |
      fl.timer2_ext_flag, fl.rx_done_flag | fl.tx_done_flag, fl.spi_flag,
      fl.timer1_overflow_flag, fl.ext1_flag, fl.timer0_overflow_flag,
      fl.adc_done_flag0 | fl.adc_done_flag1, fl.ext0_flag, wdt,
      fl.supply_monitor_flag};
    e = {sec_r[2], en_r[5:4], sec_r[0], en_r[3:1], en_r[6], en_r[0], 1'b1,
      sec_r[1]};
    h = {sec_r[6], pr_r[5:4], sec_r[4], pr_r[3:1], pr_r[6], pr_r[0], 1'b1,
      sec_r[5]};
    for (int l = 1; l >= 0; l--)
      for (int s = 0; s < 11; s++)
        if (p[s] && e[s] && h[s] == l[0] && (en_r[7] || s == 1) &&
            !act_hi && (l == 1 || !act_lo)) return s + 16 * l;
    return -1;
  endfunction : pick

  // Reference service levels and watchdog flag
  always @(posedge core_clk) begin
    int k;
    k = pick();
    if (rst) {act_hi, act_lo, wdt} = 3'b000;
    else begin
      if (reti && act_hi) act_hi = 1'b0;
      else if (reti) act_lo = 1'b0;
      if (irq_ack && irq_out.req && k >= 16) act_hi = 1'b1;
      if (irq_ack && irq_out.req && k >= 0 && k < 16) act_lo = 1'b1;
      if (wd_clr || (irq_ack && irq_out.req && k == 17)) wdt = 1'b0;
      if (tmo && wd_sel && wd_nz) wdt = 1'b1;
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] x, y);
    checks++;
    if (y !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    if (a == 8'ha8) en_r = d;
    if (a == 8'hb8) pr_r = {1'b0, d[6:0]};
    if (a == 8'ha9) sec_r = d | 8'h80;
    cyc(1);
  endtask : wr

  task automatic bwr(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = 1'b1;
    cyc(1);
    bit_wr = 1'b0;
    if (a < 8'hb0) en_r[a[2:0]] = v;
    else pr_r[a[2:0]] = v;
    cyc(1);
  endtask : bwr

  task automatic rd(input logic [7:0] a, x);
    sfr_addr = a;
    cyc(1);
    chk("sfr_rdata", 32'(x), 32'(sfr_rdata));
  endtask : rd

  task automatic check_irq();
    int k;
    k = pick();
    chk("irq req", 32'(k >= 0), 32'(irq_out.req));
    if (k >= 0) begin
      chk("irq level", 32'(k / 16), 32'(irq_out.high));
      chk("irq slot", 32'(k % 16), 32'(irq_out.slot));
      chk("irq vector", 32'(vec[k % 16]), 32'(irq_out.vector));
    end
  endtask : check_irq

  task automatic ret();
    ret_cmd = 1'b1;
    cyc(1);
    ret_cmd = 1'b0;
    cyc(3);
  endtask : ret

  task automatic pulse_tmo();
    tmo = 1'b1;
    cyc(1);
    tmo = 1'b0;
    cyc(2);
  endtask : pulse_tmo

  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    cyc(8);
    rst = 1'b0;
    rd(8'ha8, 8'h00);
    rd(8'ha9, 8'ha0);
    rd(8'hb8, 8'h00);
    rd(8'ha7, 8'h00);
    // Bit writes to both bit-addressable registers
    for (int b = 0; b < 15; b++) begin
      r = rnd();
      bwr(b < 8 ? 8'ha8 + 8'(b) : 8'hb0 + 8'(b), r[0]);
    end
    rd(8'ha8, en_r);
    rd(8'hb8, pr_r);
    // Random settings and flags against the reference, nothing taken
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      wr(8'ha8, r[7:0]);
      wr(8'hb8, r[15:8]);
      wr(8'ha9, r[23:16] & 8'hf7);
      r = rnd();
      fl = r[12:0];
      cyc(3);
      check_irq();
      rd(8'ha9, sec_r);
      rd(8'hb8, pr_r);
    end
    // Low service, high preemption, same-level hold-off, returns
    wr(8'ha9, 8'h00);
    wr(8'hb8, 8'h08);
    wr(8'ha8, 8'h89);
    fl = '0;
    fl.ext0_flag = 1'b1;
    r = rnd();
    ack_wait = r[3:0];
    ack_en = 1'b1;
    cyc(24);
    chk("pc", 32'h0003, 32'(pc));
    check_irq();
    fl.timer1_overflow_flag = 1'b1;
    cyc(24);
    chk("pc", 32'h001b, 32'(pc));
    chk("depth", 32'h2, 32'(depth));
    fl.timer1_overflow_flag = 1'b0;
    ack_en = 1'b0;
    ack_wait = 4'h0;
    ret();
    check_irq();
    ret();
    check_irq();
    // Watchdog: global enable off, select and period checked
    wr(8'ha8, 8'h00);
    fl = '0;
    {wd_sel, wd_nz} = 2'b11;
    pulse_tmo();
    chk("watchdog_flag", 32'(wdt), 32'(watchdog_flag));
    check_irq();
    wd_clr = 1'b1;
    cyc(1);
    wd_clr = 1'b0;
    cyc(2);
    wd_nz = 1'b0;
    pulse_tmo();
    chk("watchdog_flag", 32'(wdt), 32'(watchdog_flag));
    check_irq();
    {wd_sel, wd_nz} = 2'b01;
    tmo = 1'b1;
    cyc(1);
    tmo = 1'b0;
    chk("wdt_reset_req", 32'h1, 32'(wdt_reset_req));
    cyc(1);
    chk("wdt_reset_req", 32'h0, 32'(wdt_reset_req));
    wd_sel = 1'b1;
    ack_en = 1'b1;
    pulse_tmo();
    cyc(6);
    chk("pc", 32'h005b, 32'(pc));
    chk("watchdog_flag", 32'(wdt), 32'(watchdog_flag));
    ack_en = 1'b0;
    ret();
    // Wake from power-down needs the wake enable
    wr(8'ha9, 8'h01);
    fl.spi_flag = 1'b1;
    for (int w = 0; w < 4; w++) begin
      {pdown, spi_wk} = 2'(w);
      cyc(1);
      chk("wake_req", 32'(w == 3), 32'(wake_req));
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
